// File: design/dbg_pkg.sv
// Package: register map, field positions and timing constants for the debug block
package dbg_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_BRK_HIGH = 8'h00;
    localparam logic [7:0] OFF_BRK_LOW = 8'h04;
    localparam logic [7:0] OFF_BRK_AUX = 8'h08;
    localparam logic [7:0] OFF_WAIT_STATUS = 8'h0c;
    localparam logic [7:0] OFF_FLAG_CTRL = 8'h10;
    localparam logic [7:0] OFF_MON_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
    localparam logic [7:0] OFF_OSC_CTRL = 8'h20;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_WDOG_DIS = 0;
    localparam int BIT_WAIT_EXIT = 1;
    localparam int BIT_FLAG_CLR_EN = 7;
    localparam int BIT_OSC_INTERNAL = 0;
    // Interrupt event bits
    localparam int EV_MON_ENTRY = 0;
    localparam int EV_SEC_DONE = 1;
    localparam int EV_READY_SENT = 2;
    localparam int EV_BREAK_RX = 3;
    localparam int EV_WAIT_EXIT = 4;
    // ------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] VEC_PAGE_USER = 8'hff;
    localparam logic [7:0] VEC_PAGE_MON = 8'hfe;
    localparam logic [15:0] TRIM_ADDR = 16'hffc0;
    localparam int SEC_BYTES = 8;
    localparam int BREAK_BITS = 10;
    localparam int DIV_EXT = 256;
    localparam int DIV_INT = 335;
    localparam int FRAME_BITS = 10;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEC = 3'b001,
        ST_READY = 3'b010,
        ST_LINK = 3'b011,
        ST_RX = 3'b100
    } dbg_state_e;
endpackage

// File: design/dbg_break_monitor.sv
// Break registers and monitor-mode entry logic with AHB-Lite register port
//
// Behaviour
// - Breakpoint address kept as high and low byte registers, zero after reset.
// - Watchdog-disable bit set suspends watchdog during break; reset clears it.
// - Wait-exit flag set when break ended wait mode, else zero.
// - Wait status register is only in use in emulation mode.
// - In break, status clears act only when flag-clear enable is set.
// - Wait and stop keep break configuration but never raise a break.
// - Monitor link is one wired-OR pin, pulled up, driven only low.
// - Erased reset vector bytes allow monitor entry without test voltage.
// - Erased vector with interrupt pin high gives forced monitor on external clock.
// - Erased vector with interrupt pin low uses trimmed internal oscillator.
// - Monitor selection latched at internal reset rise; later pin changes ignored.
// - After monitor reset, wait for eight security bytes from host.
// - After security bytes, send ten zero bits as ready break.
// - Baud is bus clock over 256 external or 335 internal.
// - After test voltage removal, clock source follows oscillator control register.
// - Start bit plus nine zeros is recognised as a break, not data.
// - Monitor mode fetches reset, break and interrupt vectors from page FE.
`timescale 1ns/1ps
module dbg_break_monitor #(
    parameter int DIV_EXT_P = dbg_pkg::DIV_EXT,
    parameter int DIV_INT_P = dbg_pkg::DIV_INT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic int_reset_n,
    input wire logic test_high_voltage,
    input wire logic irq_pin_high,
    input wire logic mode_select_pin_a,
    input wire logic mode_select_pin_b,
    input wire logic [7:0] reset_vec_high,
    input wire logic [7:0] reset_vec_low,
    input wire logic trim_programmed,
    input wire logic [7:0] oscillator_trim_value,
    input wire logic emulation_mode,
    input wire logic break_active_flag,
    input wire logic low_power_mode,
    input wire logic wait_exit_event,
    input wire logic status_clear_req,
    input wire logic monitor_serial_pin_in,
    output logic monitor_serial_pin_out,
    output logic monitor_serial_pin_oe,
    output logic monitor_mode,
    output logic forced_monitor,
    output logic internal_osc_sel,
    output logic [7:0] osc_trim,
    output logic [15:0] breakpoint_addr,
    output logic break_request_ok,
    output logic watchdog_suspend,
    output logic status_clear_ok,
    output logic [7:0] vector_page,
    output logic baud_tick,
    output logic irq
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (DIV_EXT_P < 4 || DIV_INT_P < 4 || DIV_EXT_P > 1023 || DIV_INT_P > 1023) begin : g_chk
        $error("Baud divisors out of range");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_s_q, tv_s_q, irqp_s_q, pa_s_q, pb_s_q, ser_s_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_s_q <= 2'h0;
            tv_s_q <= 2'h0;
            irqp_s_q <= 2'h0;
            pa_s_q <= 2'h0;
            pb_s_q <= 2'h0;
            ser_s_q <= 2'h3;
        end else begin
            rst_s_q <= {rst_s_q[0], int_reset_n};
            tv_s_q <= {tv_s_q[0], test_high_voltage};
            irqp_s_q <= {irqp_s_q[0], irq_pin_high};
            pa_s_q <= {pa_s_q[0], mode_select_pin_a};
            pb_s_q <= {pb_s_q[0], mode_select_pin_b};
            ser_s_q <= {ser_s_q[0], monitor_serial_pin_in};
        end
    end
    logic rst_q, tv_q, irqp_q, pa_q, pb_q, ser_q;
    assign rst_q = rst_s_q[1];
    assign tv_q = tv_s_q[1];
    assign irqp_q = irqp_s_q[1];
    assign pa_q = pa_s_q[1];
    assign pb_q = pb_s_q[1];
    assign ser_q = ser_s_q[1];

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic wr_pend_q, rd_pend_q;
    logic [7:0] wa_q;
    logic acc;
    assign acc = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wa_q <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite;
            rd_pend_q <= acc && !hwrite;
            wa_q <= acc ? haddr[7:0] : wa_q;
        end
    end
    logic wr_en;
    assign wr_en = wr_pend_q;

    // ------------------------------------------------------------
    // Break registers
    // ------------------------------------------------------------
    logic [7:0] brk_hi_q, brk_lo_q, brk_aux_q, flag_ctrl_q, irq_mask_q, osc_ctrl_q;
    logic wait_exit_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brk_hi_q <= dbg_pkg::RST_BYTE;
            brk_lo_q <= dbg_pkg::RST_BYTE;
            brk_aux_q <= dbg_pkg::RST_BYTE;
            flag_ctrl_q <= dbg_pkg::RST_BYTE;
            irq_mask_q <= dbg_pkg::RST_BYTE;
            osc_ctrl_q <= dbg_pkg::RST_BYTE;
        end else if (wr_en) begin
            case (wa_q)
                dbg_pkg::OFF_BRK_HIGH: brk_hi_q <= hwdata[7:0];
                dbg_pkg::OFF_BRK_LOW: brk_lo_q <= hwdata[7:0];
                dbg_pkg::OFF_BRK_AUX: brk_aux_q <= hwdata[7:0];
                dbg_pkg::OFF_FLAG_CTRL: flag_ctrl_q <= hwdata[7:0];
                dbg_pkg::OFF_IRQ_MASK: irq_mask_q <= hwdata[7:0];
                dbg_pkg::OFF_OSC_CTRL: osc_ctrl_q <= hwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Wait-exit flag, only tracked in emulation mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_exit_q <= 1'b0;
        end else if (emulation_mode && wait_exit_event) begin
            wait_exit_q <= 1'b1;
        end else if (!emulation_mode || !break_active_flag) begin
            wait_exit_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Monitor entry latch
    // ------------------------------------------------------------
    logic rst_prev_q, mon_q, forced_q, int_osc_q;
    logic vec_erased;
    assign vec_erased = (reset_vec_high == dbg_pkg::ERASED_BYTE)
        && (reset_vec_low == dbg_pkg::ERASED_BYTE);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_prev_q <= 1'b0;
            mon_q <= 1'b0;
            forced_q <= 1'b0;
            int_osc_q <= 1'b0;
        end else begin
            rst_prev_q <= rst_q;
            if (rst_q && !rst_prev_q) begin
                if (tv_q && pa_q && !pb_q) begin
                    mon_q <= 1'b1;
                    forced_q <= 1'b0;
                    int_osc_q <= 1'b0;
                end else if (vec_erased) begin
                    mon_q <= 1'b1;
                    forced_q <= 1'b1;
                    int_osc_q <= !irqp_q;
                end else begin
                    mon_q <= 1'b0;
                    forced_q <= 1'b0;
                    int_osc_q <= 1'b0;
                end
            end else if (mon_q && !forced_q && !tv_q) begin
                int_osc_q <= osc_ctrl_q[dbg_pkg::BIT_OSC_INTERNAL];
            end
        end
    end

    // ------------------------------------------------------------
    // Baud divider
    // ------------------------------------------------------------
    localparam logic [9:0] DEXT = 10'(DIV_EXT_P - 1);
    localparam logic [9:0] DINT = 10'(DIV_INT_P - 1);
    dbg_pkg::dbg_state_e st_q;
    logic [9:0] div_q;
    logic tick;
    logic [9:0] div_max;
    assign div_max = int_osc_q ? DINT : DEXT;
    assign tick = (div_q == div_max);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 10'h000;
        end else if (!mon_q) begin
            div_q <= 10'h000;
        end else if ((st_q == dbg_pkg::ST_SEC || st_q == dbg_pkg::ST_LINK) && !ser_q) begin
            div_q <= div_max >> 1;
        end else if (tick) begin
            div_q <= 10'h000;
        end else begin
            div_q <= div_q + 10'h001;
        end
    end

    // ------------------------------------------------------------
    // Link sequencer: security bytes, ready break, break detect
    // ------------------------------------------------------------
    logic [3:0] bits_q, zeros_q, sec_q;
    logic drive_low_q, rxbit_one_q;
    logic ev_sec, ev_ready, ev_brk, ev_entry;
    assign ev_entry = rst_q && !rst_prev_q && (vec_erased || (tv_q && pa_q && !pb_q));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= dbg_pkg::ST_IDLE;
            bits_q <= 4'h0;
            zeros_q <= 4'h0;
            sec_q <= 4'h0;
            drive_low_q <= 1'b0;
            rxbit_one_q <= 1'b0;
        end else if (rst_q && !rst_prev_q) begin
            st_q <= dbg_pkg::ST_IDLE;
        end else begin
            case (st_q)
                dbg_pkg::ST_IDLE: begin
                    drive_low_q <= 1'b0;
                    sec_q <= 4'h0;
                    if (mon_q) begin
                        st_q <= dbg_pkg::ST_SEC;
                    end
                end
                dbg_pkg::ST_SEC, dbg_pkg::ST_LINK: begin
                    if (!ser_q) begin
                        st_q <= dbg_pkg::ST_RX;
                        bits_q <= 4'h0;
                        zeros_q <= 4'h0;
                        rxbit_one_q <= (st_q == dbg_pkg::ST_LINK);
                    end
                end
                dbg_pkg::ST_RX: begin
                    if (tick) begin
                        bits_q <= bits_q + 4'h1;
                        zeros_q <= ser_q ? zeros_q : zeros_q + 4'h1;
                        if (bits_q == 4'(dbg_pkg::FRAME_BITS - 1)) begin
                            if (rxbit_one_q) begin
                                st_q <= dbg_pkg::ST_LINK;
                            end else if (sec_q == 4'(dbg_pkg::SEC_BYTES - 1)) begin
                                st_q <= dbg_pkg::ST_READY;
                                drive_low_q <= 1'b1;
                                bits_q <= 4'h0;
                            end else begin
                                sec_q <= sec_q + 4'h1;
                                st_q <= dbg_pkg::ST_SEC;
                            end
                        end
                    end
                end
                dbg_pkg::ST_READY: begin
                    drive_low_q <= 1'b1;
                    if (tick) begin
                        bits_q <= bits_q + 4'h1;
                        if (bits_q == 4'(dbg_pkg::BREAK_BITS - 1)) begin
                            drive_low_q <= 1'b0;
                            st_q <= dbg_pkg::ST_LINK;
                        end
                    end
                end
                default: st_q <= dbg_pkg::ST_IDLE;
            endcase
        end
    end
    assign ev_sec = (st_q == dbg_pkg::ST_RX) && tick && !rxbit_one_q
        && bits_q == 4'(dbg_pkg::FRAME_BITS - 1) && sec_q == 4'(dbg_pkg::SEC_BYTES - 1);
    assign ev_ready = (st_q == dbg_pkg::ST_READY) && tick
        && bits_q == 4'(dbg_pkg::BREAK_BITS - 1);
    assign ev_brk = (st_q == dbg_pkg::ST_RX) && tick && rxbit_one_q && !ser_q
        && bits_q == 4'(dbg_pkg::FRAME_BITS - 1)
        && zeros_q == 4'(dbg_pkg::FRAME_BITS - 1);

    // ------------------------------------------------------------
    // Interrupt status, cleared by read
    // ------------------------------------------------------------
    logic [7:0] irq_st_q, ev_vec;
    logic rd_st;
    assign ev_vec = {3'h0, wait_exit_event && emulation_mode, ev_brk, ev_ready, ev_sec, ev_entry};
    assign rd_st = rd_pend_q && (wa_q == dbg_pkg::OFF_IRQ_STATUS);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_q <= 8'h00;
        end else begin
            irq_st_q <= (rd_st ? 8'h00 : irq_st_q) | ev_vec;
        end
    end

    // ------------------------------------------------------------
    // Read data and registered outputs
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        case (haddr[7:0])
            dbg_pkg::OFF_BRK_HIGH: rd_byte = brk_hi_q;
            dbg_pkg::OFF_BRK_LOW: rd_byte = brk_lo_q;
            dbg_pkg::OFF_BRK_AUX: rd_byte = brk_aux_q;
            dbg_pkg::OFF_WAIT_STATUS: rd_byte = {6'h00, wait_exit_q, 1'b0};
            dbg_pkg::OFF_FLAG_CTRL: rd_byte = flag_ctrl_q;
            dbg_pkg::OFF_MON_STATUS: rd_byte = {4'h0, 1'(st_q == dbg_pkg::ST_LINK),
                int_osc_q, forced_q, mon_q};
            dbg_pkg::OFF_IRQ_STATUS: rd_byte = irq_st_q;
            dbg_pkg::OFF_IRQ_MASK: rd_byte = irq_mask_q;
            dbg_pkg::OFF_OSC_CTRL: rd_byte = osc_ctrl_q;
            default: rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            monitor_serial_pin_out <= 1'b0;
            monitor_serial_pin_oe <= 1'b0;
            monitor_mode <= 1'b0;
            forced_monitor <= 1'b0;
            internal_osc_sel <= 1'b0;
            osc_trim <= 8'h00;
            breakpoint_addr <= 16'h0000;
            break_request_ok <= 1'b0;
            watchdog_suspend <= 1'b0;
            status_clear_ok <= 1'b0;
            vector_page <= dbg_pkg::VEC_PAGE_USER;
            baud_tick <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (acc && !hwrite) begin
                hrdata <= {24'h000000, rd_byte};
            end
            monitor_serial_pin_out <= 1'b0;
            monitor_serial_pin_oe <= drive_low_q;
            monitor_mode <= mon_q;
            forced_monitor <= forced_q;
            internal_osc_sel <= int_osc_q;
            osc_trim <= (int_osc_q && trim_programmed) ? oscillator_trim_value : 8'h00;
            breakpoint_addr <= {brk_hi_q, brk_lo_q};
            break_request_ok <= !low_power_mode;
            watchdog_suspend <= break_active_flag && brk_aux_q[dbg_pkg::BIT_WDOG_DIS];
            status_clear_ok <= status_clear_req
                && (!break_active_flag || flag_ctrl_q[dbg_pkg::BIT_FLAG_CLR_EN]);
            vector_page <= mon_q ? dbg_pkg::VEC_PAGE_MON : dbg_pkg::VEC_PAGE_USER;
            baud_tick <= tick && mon_q;
            irq <= |((irq_st_q | ev_vec) & irq_mask_q);
        end
    end
endmodule // dbg_break_monitor

// File: tb/dbg_break_monitor_sva.sv
// Checker for the debug break and monitor block ports
`timescale 1ns/1ps
module dbg_break_monitor_sva #(
    parameter int DIV_EXT_P = dbg_pkg::DIV_EXT,
    parameter int DIV_INT_P = dbg_pkg::DIV_INT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic int_reset_n,
    input wire logic low_power_mode,
    input wire logic break_active_flag,
    input wire logic status_clear_req,
    input wire logic monitor_serial_pin_out,
    input wire logic monitor_serial_pin_oe,
    input wire logic monitor_mode,
    input wire logic break_request_ok,
    input wire logic watchdog_suspend,
    input wire logic status_clear_ok,
    input wire logic [7:0] vector_page
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [15:0] oe_run_q;
    // Length of the current low drive on the link
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oe_run_q <= 16'h0000;
        end else begin
            oe_run_q <= monitor_serial_pin_oe ? oe_run_q + 16'h0001 : 16'h0000;
        end
    end
    bus_okay_a:
        assert property (hreadyout && !hresp) else $error("bus answer not ready or okay");
    pin_low_a:
        assert property (monitor_serial_pin_out == 1'b0) else $error("link pin driven high");
    ready_len_a:
        assert property ($fell(monitor_serial_pin_oe) |-> (int'(oe_run_q) == 10 * DIV_EXT_P)
            || (int'(oe_run_q) == 10 * DIV_INT_P)) else $error("ready break length wrong");
    vec_page_a:
        assert property ($stable(monitor_mode) |-> vector_page == (monitor_mode ? 8'hfe : 8'hff))
            else $error("vector page does not follow mode");
    mode_hold_a:
        assert property (int_reset_n [*8] |-> $stable(monitor_mode)) else $error("mode changed");
    lp_gate_a:
        assert property (1'b1 |=> break_request_ok == !$past(low_power_mode))
            else $error("break permit wrong in low power");
    clr_cause_a:
        assert property (status_clear_ok |-> $past(status_clear_req)) else $error("stray clear");
    clr_free_a:
        assert property (status_clear_req && !break_active_flag |=> status_clear_ok)
            else $error("clear lost outside break");
    wd_idle_a:
        assert property (!break_active_flag ##1 !break_active_flag |-> !watchdog_suspend)
            else $error("watchdog suspended outside break");
endmodule // dbg_break_monitor_sva
bind dbg_break_monitor dbg_break_monitor_sva #(
    .DIV_EXT_P(DIV_EXT_P),
    .DIV_INT_P(DIV_INT_P)
) u_sva (
    .hclk, .hresetn, .hreadyout, .hresp, .int_reset_n, .low_power_mode,
    .break_active_flag, .status_clear_req, .monitor_serial_pin_out, .monitor_serial_pin_oe,
    .monitor_mode, .break_request_ok, .watchdog_suspend, .status_clear_ok, .vector_page
);

// File: tb/dbg_host_model.sv
// Host side of the single-wire monitor link
`timescale 1ns/1ps
module dbg_host_model (
    input wire logic hclk,
    input wire logic pin_level,
    output logic pull_low
);
    int bit_len;
    int low_run;
    int last_low;
    initial begin
        bit_len = 8;
        low_run = 0;
        last_low = 0;
        pull_low = 1'b0;
    end
    // Length of the last low drive made by the device
    always @(posedge hclk) begin
        if (pin_level === 1'b0 && !pull_low) begin
            low_run++;
        end else begin
            if (low_run != 0) begin
                last_low = low_run;
            end
            low_run = 0;
        end
    end
    // Idle gap, then start, eight bits LSB first, stop; a break holds stop low
    task automatic send_frame(input logic [7:0] b, input logic brk);
        logic [9:0] fr;
        fr = {!brk, b, 1'b0};
        repeat (2 * bit_len) @(posedge hclk);
        for (int i = 0; i < 10; i++) begin
            pull_low <= !fr[i];
            repeat (bit_len) @(posedge hclk);
        end
        pull_low <= 1'b0;
    endtask
    task automatic security();
        for (int i = 0; i < 8; i++) begin
            send_frame(8'(8'ha0 + i), 1'b0);
        end
    endtask
endmodule // dbg_host_model

// File: tb/test_break_regs_and_monitor_entry.sv
// Testbench for the debug break and monitor block
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module test_break_regs_and_monitor_entry;
    localparam int DIV_E = 8;
    localparam int DIV_I = 10;
    localparam logic [7:0] MODE_TAB [5] = '{8'h10, 8'h90, 8'h1e, 8'h0f, 8'hd4};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, int_reset_n, tv, irq_hi, pa, pb;
    logic [31:0] haddr, hwdata, hrdata, dummy;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] vec, bp_addr;
    logic [7:0] trim_val, osc_trim, vpage, c;
    logic trim_prog, emu, brk, lpm, wexit, clr_req, pin_level, host_low, pout, oe;
    logic mon, forced, int_osc, brk_ok, wd_susp, clr_ok, irq;
    int num_errors, checks_done, cycles, n;
    assign pin_level = !((oe && !pout) || host_low);
    dbg_break_monitor #(.DIV_EXT_P(DIV_E), .DIV_INT_P(DIV_I)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .int_reset_n(int_reset_n),
        .test_high_voltage(tv), .irq_pin_high(irq_hi), .mode_select_pin_a(pa),
        .mode_select_pin_b(pb), .reset_vec_high(vec[15:8]), .reset_vec_low(vec[7:0]),
        .trim_programmed(trim_prog), .oscillator_trim_value(trim_val), .emulation_mode(emu),
        .break_active_flag(brk), .low_power_mode(lpm), .wait_exit_event(wexit),
        .status_clear_req(clr_req), .monitor_serial_pin_in(pin_level),
        .monitor_serial_pin_out(pout), .monitor_serial_pin_oe(oe), .monitor_mode(mon),
        .forced_monitor(forced), .internal_osc_sel(int_osc), .osc_trim(osc_trim),
        .breakpoint_addr(bp_addr), .break_request_ok(brk_ok), .watchdog_suspend(wd_susp),
        .status_clear_ok(clr_ok), .vector_page(vpage), .baud_tick(), .irq(irq)
    );
    dbg_host_model host (.hclk(hclk), .pin_level(pin_level), .pull_low(host_low));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles > 30000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        k = 0;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        k = 0;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
        dummy = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h000000, d});
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 32'h00000000);
        `CHECK(nm, exp, dummy[7:0])
    endtask
    task automatic clr_try(input logic exp);
        @(posedge hclk);
        clr_req <= 1'b1;
        @(posedge hclk);
        clr_req <= 1'b0;
        @(posedge hclk);
        `CHECK("clear_ok", exp, clr_ok)
    endtask
    initial begin
        {hresetn, hsel, hwrite, int_reset_n, tv, irq_hi, pa, pb} = 8'h00;
        {emu, brk, lpm, wexit, clr_req} = 5'h00;
        num_errors = 0;
        checks_done = 0;
        cycles = 0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        htrans = 2'b00;
        hsize = 3'b010;
        vec = 16'h1234;
        trim_prog = 1'b1;
        trim_val = 8'h5a;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd_chk("reset_val", 8'(4 * i), 8'h00);
        wr(8'h40, 8'h5a);
        rd_chk("unmapped", 8'h40, 8'h00);
        wr(8'h00, 8'h12);
        wr(8'h04, 8'h34);
        rd_chk("bp_high", 8'h00, 8'h12);
        `CHECK("bp_addr", 16'h1234, bp_addr)
        wr(8'h08, 8'h01);
        brk <= 1'b1;
        repeat (3) @(posedge hclk);
        `CHECK("wd_suspend", 1'b1, wd_susp)
        wr(8'h08, 8'h00);
        repeat (3) @(posedge hclk);
        `CHECK("wd_running", 1'b0, wd_susp)
        emu <= 1'b1;
        wexit <= 1'b1;
        @(posedge hclk);
        wexit <= 1'b0;
        rd_chk("wait_flag", 8'h0c, 8'h02);
        emu <= 1'b0;
        rd_chk("wait_no_emu", 8'h0c, 8'h00);
        clr_try(1'b0);
        wr(8'h10, 8'h80);
        clr_try(1'b1);
        lpm <= 1'b1;
        repeat (3) @(posedge hclk);
        `CHECK("break_ok_low", 1'b0, brk_ok)
        rd_chk("bp_kept", 8'h04, 8'h34);
        lpm <= 1'b0;
        brk <= 1'b0;
        repeat (3) @(posedge hclk);
        `CHECK("break_ok", 1'b1, brk_ok)
        $display("test break registers done");
        for (int i = 0; i < 5; i++) begin
            c = MODE_TAB[i];
            xfer(1'b0, 8'h18, 32'h00000000);
            @(posedge hclk);
            int_reset_n <= 1'b0;
            {tv, pa, pb, irq_hi} <= c[7:4];
            vec <= c[3] ? 16'hffff : 16'h1234;
            repeat (4) @(posedge hclk);
            int_reset_n <= 1'b1;
            repeat (8) @(posedge hclk);
            `CHECK("monitor", c[2], mon)
            `CHECK("forced", c[1], forced)
            `CHECK("int_osc", c[0], int_osc)
            `CHECK("trim", c[0] ? 8'h5a : 8'h00, osc_trim)
            `CHECK("vec_page", c[2] ? 8'hfe : 8'hff, vpage)
            rd_chk("mon_status", 8'h14, {5'h00, c[0], c[1], c[2]});
            if (c[2]) begin
                wr(8'h1c, 8'h1f);
                host.bit_len = c[0] ? DIV_I : DIV_E;
                host.last_low = 0;
                host.security();
                for (n = 0; n < 3000 && host.last_low == 0; n++) @(posedge hclk);
                `CHECK("ready_len", 10 * host.bit_len, host.last_low)
                `CHECK("irq_on", 1'b1, irq)
                rd_chk("status_ready", 8'h18, 8'h07);
                repeat (3) @(posedge hclk);
                `CHECK("irq_off", 1'b0, irq)
                repeat (12 * DIV_I) @(posedge hclk);
                host.send_frame(8'h00, 1'b0);
                repeat (2 * DIV_I) @(posedge hclk);
                rd_chk("status_data", 8'h18, 8'h00);
                wr(8'h1c, 8'h00);
                host.send_frame(8'h00, 1'b1);
                repeat (2 * DIV_I) @(posedge hclk);
                `CHECK("irq_masked", 1'b0, irq)
                rd_chk("status_break", 8'h18, 8'h08);
                wr(8'h1c, 8'h00);
            end
            $display("test mode entry %0d done", i);
        end
        pa <= 1'b0;
        pb <= 1'b1;
        repeat (8) @(posedge hclk);
        `CHECK("mode_kept", 1'b1, mon)
        tv <= 1'b0;
        wr(8'h20, 8'h01);
        repeat (3) @(posedge hclk);
        `CHECK("osc_by_reg", 1'b1, int_osc)
        wr(8'h20, 8'h00);
        repeat (3) @(posedge hclk);
        `CHECK("osc_by_reg_off", 1'b0, int_osc)
        $display("test clock source done");
        close_out();
    end
endmodule // test_break_regs_and_monitor_entry
